// [logic/sbg_pkg.sv]
// package for the serial baud rate generator: map, fields, ratios, bus carriers
package sbg_pkg;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned PRE_W  = 6;

    // register byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] OFF_RX_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_DIVISOR = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_TX_CTRL = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_COUNT   = 5'h0c;

    // register select codes
    localparam logic [2:0] SEL_RX_CTRL = 3'h0;
    localparam logic [2:0] SEL_DIVISOR = 3'h1;
    localparam logic [2:0] SEL_TX_CTRL = 3'h2;
    localparam logic [2:0] SEL_COUNT   = 3'h3;
    localparam logic [2:0] SEL_NONE    = 3'h4;

    // reset values
    localparam logic [REG_W-1:0] RST_RX_CTRL = 8'h00;
    localparam logic [REG_W-1:0] RST_DIVISOR = 8'h00;
    localparam logic [REG_W-1:0] RST_TX_CTRL = 8'h02;

    // writable bits; the rest keep their reset value
    localparam logic [REG_W-1:0] WMASK_RX_CTRL = 8'hf8;
    localparam logic [REG_W-1:0] WMASK_TX_CTRL = 8'hf5;

    // field positions
    localparam int unsigned BIT_PORT_ENABLE = 7;
    localparam int unsigned BIT_SYNC_MODE   = 4;
    localparam int unsigned BIT_HIGH_SPEED  = 2;

    // prescaler ratios minus one: async low 64, async high 16, sync 4
    localparam logic [PRE_W-1:0] RATIO_LS_M1   = 6'h3f;
    localparam logic [PRE_W-1:0] RATIO_HS_M1   = 6'h0f;
    localparam logic [PRE_W-1:0] RATIO_SYNC_M1 = 6'h03;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } sbg_axi_req_s;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } sbg_axi_rsp_s;
endpackage : sbg_pkg

// [logic/sbg_prescaler.sv]
// mode prescaler that turns timer reloads into baud ticks
`timescale 1ns/1ns
`default_nettype none
module sbg_prescaler #(
    parameter int unsigned CNT_W = 6
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic [CNT_W-1:0] ratio_m1,
    output logic                  tick
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (clear) begin
            cnt_d = '0;
        end else if (step) begin
            // >= so a smaller ratio picked mid-count still wraps at once
            if (cnt_q >= ratio_m1) begin
                cnt_d  = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : sbg_prescaler
`default_nettype wire

// [logic/sbg_baud_gen.sv]
// serial baud rate generator with its control registers on axi4-lite
// Summary of operation
// - one dedicated 8-bit timer times bits for async and sync modes
// - timer runs freely; its period comes from the baud divisor register
// - async mode picks the period multiplier from the high speed select bit
// - sync mode ignores the high speed select bit entirely
// - rate is clock/64(n+1) async low, clock/16(n+1) async high, clock/4(n+1) sync
// - a divisor write with byte lane 0 enabled clears the timer at once
// - with the port enable bit clear the timer is held in reset
// - mode bit set selects synchronous, clear selects asynchronous
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module sbg_baud_gen #(
    parameter int unsigned TIMER_W = 8
) (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire sbg_pkg::sbg_axi_req_s axi_req,
    output sbg_pkg::sbg_axi_rsp_s      axi_rsp,
    output logic                       baud_tick,
    output logic                       serial_port_enable,
    output logic                       sync_mode
);
    function automatic logic [2:0] reg_sel(input logic [sbg_pkg::ADDR_W-1:0] addr);
        logic [sbg_pkg::ADDR_W-1:0] word;
        word = {addr[sbg_pkg::ADDR_W-1:2], 2'b00};
        unique case (word)
            sbg_pkg::OFF_RX_CTRL: reg_sel = sbg_pkg::SEL_RX_CTRL;
            sbg_pkg::OFF_DIVISOR: reg_sel = sbg_pkg::SEL_DIVISOR;
            sbg_pkg::OFF_TX_CTRL: reg_sel = sbg_pkg::SEL_TX_CTRL;
            sbg_pkg::OFF_COUNT:   reg_sel = sbg_pkg::SEL_COUNT;
            default:              reg_sel = sbg_pkg::SEL_NONE;
        endcase
    endfunction : reg_sel

    function automatic logic [sbg_pkg::REG_W-1:0] merge(
        input logic [sbg_pkg::REG_W-1:0] old_val,
        input logic [sbg_pkg::REG_W-1:0] new_val,
        input logic [sbg_pkg::REG_W-1:0] mask
    );
        merge = (new_val & mask) | (old_val & ~mask);
    endfunction : merge

    // bus slave state
    logic                        aw_have_q;
    logic                        aw_have_d;
    logic [sbg_pkg::ADDR_W-1:0]  aw_addr_q;
    logic [sbg_pkg::ADDR_W-1:0]  aw_addr_d;
    logic                        w_have_q;
    logic                        w_have_d;
    logic [sbg_pkg::REG_W-1:0]   w_data_q;
    logic [sbg_pkg::REG_W-1:0]   w_data_d;
    logic                        w_lane_q;
    logic                        w_lane_d;
    logic                        bvalid_q;
    logic                        bvalid_d;
    logic [1:0]                  bresp_q;
    logic [1:0]                  bresp_d;
    logic                        rvalid_q;
    logic                        rvalid_d;
    logic [sbg_pkg::DATA_W-1:0]  rdata_q;
    logic [sbg_pkg::DATA_W-1:0]  rdata_d;
    logic [1:0]                  rresp_q;
    logic [1:0]                  rresp_d;

    // registers
    logic [sbg_pkg::REG_W-1:0]   rx_ctrl_q;
    logic [sbg_pkg::REG_W-1:0]   rx_ctrl_d;
    logic [sbg_pkg::REG_W-1:0]   divisor_q;
    logic [sbg_pkg::REG_W-1:0]   divisor_d;
    logic [sbg_pkg::REG_W-1:0]   tx_ctrl_q;
    logic [sbg_pkg::REG_W-1:0]   tx_ctrl_d;

    // timer
    logic [TIMER_W-1:0]          count_q;
    logic [TIMER_W-1:0]          count_d;
    logic                        step_q;
    logic                        step_d;

    logic                        awready;
    logic                        wready;
    logic                        arready;
    logic                        commit;
    logic [2:0]                  wsel;
    logic [2:0]                  rsel;
    logic                        div_write;
    logic                        enable;
    logic                        sync_sel;
    logic                        high_speed;
    logic [sbg_pkg::PRE_W-1:0]   ratio_m1;

    assign awready = !aw_have_q && !bvalid_q;
    assign wready  = !w_have_q && !bvalid_q;
    assign arready = !rvalid_q;
    // write goes through once address and data are both held
    assign commit  = aw_have_q && w_have_q && !bvalid_q;
    assign wsel    = reg_sel(aw_addr_q);
    assign rsel    = reg_sel(axi_req.araddr);

    assign div_write  = commit && w_lane_q && (wsel == sbg_pkg::SEL_DIVISOR);
    assign enable     = rx_ctrl_q[sbg_pkg::BIT_PORT_ENABLE];
    assign sync_sel   = tx_ctrl_q[sbg_pkg::BIT_SYNC_MODE];
    assign high_speed = tx_ctrl_q[sbg_pkg::BIT_HIGH_SPEED];

    // bus channels
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_lane_d  = w_lane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (axi_req.awvalid && awready) begin
            aw_have_d = 1'b1;
            aw_addr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && wready) begin
            w_have_d = 1'b1;
            w_data_d = axi_req.wdata[sbg_pkg::REG_W-1:0];
            w_lane_d = axi_req.wstrb[0];
        end
        if (commit) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (wsel == sbg_pkg::SEL_NONE) ? sbg_pkg::RESP_SLVERR
                                                    : sbg_pkg::RESP_OKAY;
        end
        if (bvalid_q && axi_req.bready) begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && axi_req.rready) begin
            rvalid_d = 1'b0;
        end
        if (axi_req.arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d  = sbg_pkg::RESP_OKAY;
            rdata_d  = '0;
            unique case (rsel)
                sbg_pkg::SEL_RX_CTRL: rdata_d[sbg_pkg::REG_W-1:0] = rx_ctrl_q;
                sbg_pkg::SEL_DIVISOR: rdata_d[sbg_pkg::REG_W-1:0] = divisor_q;
                sbg_pkg::SEL_TX_CTRL: rdata_d[sbg_pkg::REG_W-1:0] = tx_ctrl_q;
                sbg_pkg::SEL_COUNT:   rdata_d[TIMER_W-1:0] = count_q;
                default:              rresp_d = sbg_pkg::RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_have_q  <= 1'b0;
            w_data_q  <= '0;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= sbg_pkg::RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= sbg_pkg::RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_lane_q  <= w_lane_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // register file; only byte lane 0 carries data
    always_comb begin
        rx_ctrl_d = rx_ctrl_q;
        divisor_d = divisor_q;
        tx_ctrl_d = tx_ctrl_q;
        if (commit && w_lane_q) begin
            unique case (wsel)
                sbg_pkg::SEL_RX_CTRL:
                    rx_ctrl_d = merge(rx_ctrl_q, w_data_q, sbg_pkg::WMASK_RX_CTRL);
                sbg_pkg::SEL_DIVISOR: divisor_d = w_data_q;
                sbg_pkg::SEL_TX_CTRL:
                    tx_ctrl_d = merge(tx_ctrl_q, w_data_q, sbg_pkg::WMASK_TX_CTRL);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rx_ctrl_q <= sbg_pkg::RST_RX_CTRL;
            divisor_q <= sbg_pkg::RST_DIVISOR;
            tx_ctrl_q <= sbg_pkg::RST_TX_CTRL;
        end else begin
            rx_ctrl_q <= rx_ctrl_d;
            divisor_q <= divisor_d;
            tx_ctrl_q <= tx_ctrl_d;
        end
    end

    // free running reload timer
    always_comb begin
        count_d = count_q;
        step_d  = 1'b0;
        if (!enable || div_write) begin
            count_d = '0;
        end else if (count_q == TIMER_W'(divisor_q)) begin
            count_d = '0;
            step_d  = 1'b1;
        end else begin
            count_d = count_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
            step_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            step_q  <= step_d;
        end
    end

    // multiplier: high speed select only counts in async mode
    always_comb begin
        if (sync_sel) begin
            ratio_m1 = sbg_pkg::RATIO_SYNC_M1;
        end else if (high_speed) begin
            ratio_m1 = sbg_pkg::RATIO_HS_M1;
        end else begin
            ratio_m1 = sbg_pkg::RATIO_LS_M1;
        end
    end

    sbg_prescaler #(
        .CNT_W    (sbg_pkg::PRE_W)
    ) u_prescaler (
        .clock    (clock),
        .rst_b    (rst_b),
        .clear    (!enable || div_write),
        .step     (step_q && enable),
        .ratio_m1 (ratio_m1),
        .tick     (baud_tick)
    );

    assign serial_port_enable = enable;
    assign sync_mode          = sync_sel;

    always_comb begin
        axi_rsp         = '0;
        axi_rsp.awready = awready;
        axi_rsp.wready  = wready;
        axi_rsp.bvalid  = bvalid_q;
        axi_rsp.bresp   = bresp_q;
        axi_rsp.arready = arready;
        axi_rsp.rvalid  = rvalid_q;
        axi_rsp.rdata   = rdata_q;
        axi_rsp.rresp   = rresp_q;
    end
endmodule : sbg_baud_gen
`default_nettype wire

// [tb/sbg_baud_gen_properties.sv]
// port checker for the serial baud rate generator
`timescale 1ns/1ns
`default_nettype none
module sbg_baud_gen_properties #(
    parameter int unsigned TIMER_W = 8
) (
    input wire logic                  clock,
    input wire logic                  rst_b,
    input wire sbg_pkg::sbg_axi_req_s axi_req,
    input wire sbg_pkg::sbg_axi_rsp_s axi_rsp,
    input wire logic                  baud_tick,
    input wire logic                  serial_port_enable,
    input wire logic                  sync_mode
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // shortest ratio is 4, so ticks never come closer
    tick_gap_a: assert property (baud_tick |=> !baud_tick [*3])
        else $error("baud ticks closer than four cycles");
    idle_quiet_a: assert property (
        !serial_port_enable && !$past(serial_port_enable) |-> !baud_tick)
        else $error("baud tick while port disabled");
    enable_start_a: assert property ($rose(serial_port_enable) |-> !baud_tick [*4])
        else $error("baud tick too soon after enable");
    b_hold_a: assert property (
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped early");
    b_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while response pending");
    r_lat_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    w_lat_a: assert property (
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |-> ##[1:2] axi_rsp.bvalid)
        else $error("write answer late");
    cover property (baud_tick && sync_mode);
    cover property (baud_tick && !sync_mode);
    cover property (axi_rsp.bvalid && axi_rsp.bresp == sbg_pkg::RESP_SLVERR);
endmodule : sbg_baud_gen_properties
bind sbg_baud_gen sbg_baud_gen_properties #(.TIMER_W(TIMER_W)) sbg_baud_gen_properties_i (
    .clock(clock), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .baud_tick(baud_tick), .serial_port_enable(serial_port_enable), .sync_mode(sync_mode));
`default_nettype wire

// [tb/sbg_baud_gen_test.sv]
// self-checking testbench for the serial baud rate generator
`timescale 1ns/1ns
`default_nettype none
module sbg_baud_gen_test;
    logic                  clock;
    logic                  rst_b;
    sbg_pkg::sbg_axi_req_s req;
    sbg_pkg::sbg_axi_rsp_s rsp;
    logic                  baud_tick;
    logic                  serial_port_enable;
    logic                  sync_mode;
    int                    fails;
    int                    num_checks;
    int                    seed;
    int                    i;
    int                    k;
    int                    n;
    logic                  s;
    logic                  h;
    logic [31:0]           d;
    logic [1:0]            r;
    logic [3:0]            strb;
    logic [7:0]            rstv [3] = '{8'h00, 8'h00, 8'h02};

    sbg_baud_gen sbg_baud_gen_i (.clock(clock), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp),
        .baud_tick(baud_tick), .serial_port_enable(serial_port_enable), .sync_mode(sync_mode));

    task print_verdict;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task give_up(input string what);
        fails++;
        $display("CHECK FAILED %s expected answer seen timeout", what);
        print_verdict();
    endtask : give_up

    function automatic int exp_period(input logic sy, input logic hs, input int dv);
        return (sy ? 4 : (hs ? 16 : 64)) * (dv + 1);
    endfunction : exp_period

    task wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= strb;
        req.bready  <= 1'b1;
        for (int t = 0; t < 100; t++) begin
            @(negedge clock);
            ah = req.awvalid & rsp.awready;
            wh = req.wvalid & rsp.wready;
            bh = rsp.bvalid === 1'b1;
            rs = rsp.bresp;
            @(posedge clock);
            if (ah) req.awvalid <= 1'b0;
            if (wh) req.wvalid <= 1'b0;
            if (bh) begin
                req.bready <= 1'b0;
                return;
            end
        end
        give_up("write");
    endtask : wr

    task rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ah, rh;
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        for (int t = 0; t < 100; t++) begin
            @(negedge clock);
            ah = req.arvalid & rsp.arready;
            rh = rsp.rvalid === 1'b1;
            v = rsp.rdata;
            rs = rsp.rresp;
            @(posedge clock);
            if (ah) req.arvalid <= 1'b0;
            if (rh) begin
                req.rready <= 1'b0;
                return;
            end
        end
        give_up("read");
    endtask : rd

    // counts negedges until a tick is seen
    task wait_tick(input int lim, output int cnt);
        for (cnt = 1; cnt <= lim; cnt++) begin
            @(negedge clock);
            if (baud_tick === 1'b1) return;
        end
        give_up("baud tick");
    endtask : wait_tick

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        seed = 36;
        fails = 0;
        num_checks = 0;
        strb = 4'hf;
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        for (i = 0; i < 3; i++) begin
            rd(5'(4 * i), d, r);
            check("reset value", {24'h0, rstv[i]}, d);
        end
        rd(5'h10, d, r);
        check("unmapped rresp", 32'(sbg_pkg::RESP_SLVERR), 32'(r));
        wr(5'h14, 32'hff, r);
        check("unmapped bresp", 32'(sbg_pkg::RESP_SLVERR), 32'(r));
        // byte lane 0 off: the divisor must keep its value
        strb = 4'he;
        wr(sbg_pkg::OFF_DIVISOR, 32'hff, r);
        strb = 4'hf;
        rd(sbg_pkg::OFF_DIVISOR, d, r);
        check("masked divisor", 32'(sbg_pkg::RST_DIVISOR), d);
        wr(sbg_pkg::OFF_TX_CTRL, 32'hff, r);
        check("tx ctrl bresp", 32'(sbg_pkg::RESP_OKAY), 32'(r));
        rd(sbg_pkg::OFF_TX_CTRL, d, r);
        check("tx ctrl bits", 32'hf7, d);
        for (i = 0; i < 5; i++) begin
            s = i[0] | (i == 4);
            h = i[1];
            n = (i == 1) ? 0 : (i == 4) ? 255 : ($random(seed) & 15);
            wr(sbg_pkg::OFF_TX_CTRL, {27'h0, s, 1'b0, h, 2'h0}, r);
            d = $random(seed);
            d[7:0] = 8'(n);
            wr(sbg_pkg::OFF_DIVISOR, d, r);
            wr(sbg_pkg::OFF_RX_CTRL, 32'h80, r);
            check("sync_mode", 32'(s), 32'(sync_mode));
            wait_tick(20000, k);
            wait_tick(20000, k);
            check("period", 32'(exp_period(s, h, n)), 32'(k));
        end
        // slow rate first, then a fast divisor must take over at once
        wr(sbg_pkg::OFF_TX_CTRL, 32'h0, r);
        wr(sbg_pkg::OFF_DIVISOR, 32'd200, r);
        repeat (100) @(posedge clock);
        wr(sbg_pkg::OFF_DIVISOR, 32'd3, r);
        wait_tick(20000, k);
        check("restart delay", 32'h1, 32'(k >= 254 && k <= 258));
        wr(sbg_pkg::OFF_RX_CTRL, 32'h0, r);
        k = 0;
        repeat (300) begin
            @(negedge clock);
            k += int'(baud_tick !== 1'b0);
        end
        check("ticks while disabled", 32'h0, 32'(k));
        rd(sbg_pkg::OFF_COUNT, d, r);
        check("held timer count", 32'h0, d);
        check("port enable", 32'h0, 32'(serial_port_enable));
        print_verdict();
    end
endmodule : sbg_baud_gen_test
`default_nettype wire
